// File: hw/audio_serial_ctrl.sv
// Purpose: Register file and control logic of a DMA-fed audio serial port
// Assumes: Single clock; DMA, FIFO and link events arrive as synchronous pulses
// Notes: AXI4-Lite slave answers a read one cycle and a write two cycles after acceptance
// How it works
// - Transmit data fetched bytewise when data mode bit is zero.
// - Transmit data fetched in bursts when data mode bit is one.
// - Receive descriptor fetch mode bit: one burst, zero bytewise.
// - Transmit descriptor fetch mode bit: one burst, zero bytewise.
// - Frame end on DMA pop-done in mode one, else bus push-done.
// - Auto writeback writes transmit descriptor once its buffer is sent.
// - Separate bits put transmit and receive chains into loop test.
// - Bus master port reset and command queue reset act independently.
// - Transmit and receive DMA state machine resets act independently.
// - Enabled hang counter reaching timeout raises send or receive timeout.
// - With stop option, bit clock and word select halt while FIFO empty.
// - Receive companding bypassed, else zero decompresses and one compresses.
// - Transmit companding bypassed, else zero decompresses and one compresses.
// - Force bits power FIFO memory up or down, overriding automatic control.
// - Divider takes integral, numerator, denominator; separate audio PLL enable.
// - A bit bypasses the transmit PDM high-pass filter.
// - Receive PDM first filter group downsamples by 128 or 64.
// - Gain codes: zero halves, one unity, two doubles, three quadruples.
// - Transmit sinc upsampling equals 64 times oversample field.
// - Separate enables for both converters and both PDM modes.
// - Conversion ratio from PDM frequency and PCM frequency parameters.
// - FIFO reset-done flags read one while reset runs, zero when done.
// - Transmitter idle flag reads one idle, zero busy.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module audio_serial_ctrl
    import audio_serial_pkg::*;
#(
    parameter int HANG_W = 8
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // DMA and FIFO events
    input wire logic dmaPopDone,
    input wire logic busPushDone,
    input wire logic txBufferSent,
    input wire logic txFifoEmpty,
    input wire logic txFifoHang,
    input wire logic rxFifoHang,
    input wire logic fifoResetReq,
    input wire logic txActive,
    input wire logic [31:0] rxDmaState,
    input wire logic [31:0] dmaStateOne,
    input wire logic mclkSource,
    // Control towards DMA and datapath
    output audio_serial_pkg::ctrl_t ctrl,
    output audio_serial_pkg::pdm_t pdm,
    output audio_serial_pkg::gain_t [3:0] txGain,
    output logic txEofPulse,
    output logic descWritebackPulse,
    output logic txTimeoutPulse,
    output logic rxTimeoutPulse,
    output logic mclkTick,
    output logic serialClockEnable
);
    import audio_serial_pkg::*;

    // All checks below run on the one clock
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic [31:0] linkConf_q, codecConf_q, powerConf_q, clkConf_q, pdmConf_q, freqConf_q;
    logic awHeld_q, wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic [HANG_W-1:0] txHang_q, rxHang_q;
    logic [3:0] fifoRst_q;
    logic [8:0] divCnt_q;
    logic [6:0] fracAcc_q;
    logic [7:0] divNum;
    logic [5:0] divNumer, divDenom;

    // Write channels taken independently, then joined
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data holding
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            else if (doWrite)
                awHeld_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            else if (doWrite)
                wHeld_q <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    // Register writes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            linkConf_q <= RST_LINK;
            codecConf_q <= RST_CODEC;
            powerConf_q <= RST_LINK;
            clkConf_q <= RST_CLK;
            pdmConf_q <= RST_PDM;
            freqConf_q <= RST_FREQ;
        end
        else if (doWrite)
        begin
            unique case (awAddr_q)
                OFS_LINK_CONF: linkConf_q <= merge(linkConf_q, wData_q, wStrb_q);
                OFS_CODEC_CONF: codecConf_q <= merge(codecConf_q, wData_q, wStrb_q);
                OFS_FIFO_POWER: powerConf_q <= merge(powerConf_q, wData_q, wStrb_q);
                OFS_CLK_DIV: clkConf_q <= merge(clkConf_q, wData_q, wStrb_q);
                OFS_PDM_CONF: pdmConf_q <= merge(pdmConf_q, wData_q, wStrb_q);
                OFS_PDM_FREQ: freqConf_q <= merge(freqConf_q, wData_q, wStrb_q);
                default: ;
            endcase
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            unique case (awAddr_q)
                OFS_LINK_CONF, OFS_CODEC_CONF, OFS_FIFO_POWER, OFS_CLK_DIV, OFS_PDM_CONF,
                OFS_PDM_FREQ: s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read data path
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_LINK_CONF: s_axi_rdata <= linkConf_q;
                OFS_RX_DMA_STAT: s_axi_rdata <= rxDmaState;
                OFS_DMA_STAT_ONE: s_axi_rdata <= dmaStateOne;
                OFS_CODEC_CONF: s_axi_rdata <= codecConf_q;
                OFS_FIFO_POWER: s_axi_rdata <= powerConf_q;
                OFS_CLK_DIV: s_axi_rdata <= clkConf_q;
                OFS_PDM_CONF: s_axi_rdata <= pdmConf_q;
                OFS_PDM_FREQ: s_axi_rdata <= freqConf_q;
                // Reset-done pair and idle flag
                OFS_STATUS: s_axi_rdata <= {29'h0, !txActive, fifoRst_q != 4'h0,
                                            fifoRst_q != 4'h0};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Control decode towards DMA and companding
    always_comb
    begin
        ctrl.txDataBurst = linkConf_q[B_TX_DATA_BURST];
        ctrl.rxDscrBurst = linkConf_q[B_RX_DSCR_BURST];
        ctrl.txDscrBurst = linkConf_q[B_TX_DSCR_BURST];
        ctrl.autoWriteback = linkConf_q[B_AUTO_WRBACK];
        ctrl.txLoop = linkConf_q[B_TX_LOOP];
        ctrl.rxLoop = linkConf_q[B_RX_LOOP];
        ctrl.busPortReset = linkConf_q[B_BUS_RST];
        ctrl.cmdQueueReset = linkConf_q[B_QUEUE_RST];
        ctrl.txFsmReset = linkConf_q[B_TX_FSM_RST];
        ctrl.rxFsmReset = linkConf_q[B_RX_FSM_RST];
        ctrl.rxCompandBypass = codecConf_q[B_RX_CMP_BYP];
        ctrl.rxCompress = codecConf_q[B_RX_CMP_DIR];
        ctrl.txCompandBypass = codecConf_q[B_TX_CMP_BYP];
        ctrl.txCompress = codecConf_q[B_TX_CMP_DIR];
        // Force down wins over force up; otherwise follow activity
        ctrl.memPowerOn = powerConf_q[B_FORCE_PD] ? 1'b0 :
                          (powerConf_q[B_FORCE_PU] | txActive);
        ctrl.apllEnable = clkConf_q[21];
    end

    // Filter settings decode
    always_comb
    begin
        pdm.txHighpassBypass = pdmConf_q[0];
        pdm.rxDownsample = pdmConf_q[1] ? 8'(DSR_HIGH) : 8'(DSR_LOW);
        pdm.txUpsample = 10'(SINC_BASE) * {6'h0, pdmConf_q[13:10]};
        pdm.d2pEnable = pdmConf_q[24];
        pdm.p2dEnable = pdmConf_q[25];
        pdm.rxPdmEnable = pdmConf_q[26];
        pdm.txPdmEnable = pdmConf_q[27];
        pdm.freqParam = freqConf_q[19:10];
        pdm.sampleParam = freqConf_q[9:0];
    end

    // Four gain fields from bits 2..9
    for (genvar g = 0; g < 4; g++)
    begin : gainGen
        assign txGain[g] = gain_t'(pdmConf_q[2+2*g +: 2]);
    end

    // Frame end and writeback events
    assign txEofPulse = linkConf_q[B_EOF_MODE] ? dmaPopDone : busPushDone;
    assign descWritebackPulse = ctrl.autoWriteback && txBufferSent;
    assign serialClockEnable = !(codecConf_q[B_TX_STOP] && txFifoEmpty);

    // Hang counters wrap; a pulse each time the count equals the programmed value
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txHang_q <= '0;
            rxHang_q <= '0;
        end
        else
        begin
            txHang_q <= (codecConf_q[B_TIMEOUT_EN] && txFifoHang) ? txHang_q + 1'b1 : '0;
            rxHang_q <= (codecConf_q[B_TIMEOUT_EN] && rxFifoHang) ? rxHang_q + 1'b1 : '0;
        end
    end
    assign txTimeoutPulse = codecConf_q[B_TIMEOUT_EN] && txFifoHang &&
                            (txHang_q == HANG_W'(codecConf_q[7:0]));
    assign rxTimeoutPulse = codecConf_q[B_TIMEOUT_EN] && rxFifoHang &&
                            (rxHang_q == HANG_W'(codecConf_q[7:0]));

    // FIFO reset in progress window
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            fifoRst_q <= 4'h0;
        else if (fifoResetReq)
            fifoRst_q <= FIFO_RST_CYCLES;
        else if (fifoRst_q != 4'h0)
            fifoRst_q <= fifoRst_q - 4'h1;
    end

    // Fractional divider: stretch by one when the fraction wraps
    assign divNum = (clkConf_q[7:0] < DIV_MIN) ? DIV_MIN : clkConf_q[7:0];
    assign divNumer = clkConf_q[13:8];
    assign divDenom = clkConf_q[19:14];
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt_q <= 9'h000;
            fracAcc_q <= 7'h00;
            mclkTick <= 1'b0;
        end
        else if (mclkSource)
        begin
            mclkTick <= 1'b0;
            if (divCnt_q == 9'h000)
            begin
                mclkTick <= 1'b1;
                if (divDenom != 6'h00 && ({1'b0, fracAcc_q} + {2'h0, divNumer}) >=
                    {2'h0, divDenom})
                begin
                    fracAcc_q <= 7'(fracAcc_q + {1'b0, divNumer} - {1'b0, divDenom});
                    divCnt_q <= {1'b0, divNum};
                end
                else
                begin
                    fracAcc_q <= (divDenom != 6'h00) ? 7'(fracAcc_q + {1'b0, divNumer}) : 7'h00;
                    divCnt_q <= {1'b0, divNum} - 9'h001;
                end
            end
            else
                divCnt_q <= divCnt_q - 9'h001;
        end
        else
            mclkTick <= 1'b0;
    end

    a_eof_source: assert property (
        dmaPopDone != busPushDone |-> txEofPulse == (dmaPopDone == linkConf_q[B_EOF_MODE]))
        else $error("eof source wrong");
    a_wrback_event: assert property (
        descWritebackPulse |-> txBufferSent && linkConf_q[B_AUTO_WRBACK])
        else $error("writeback without enable");
    a_hang_timeout: assert property (
        txTimeoutPulse |-> codecConf_q[B_TIMEOUT_EN])
        else $error("timeout while disabled");
    a_stop_clock: assert property (
        codecConf_q[B_TX_STOP] && txFifoEmpty |-> !serialClockEnable)
        else $error("clock runs on empty fifo");
    a_power_force: assert property (
        powerConf_q[B_FORCE_PD] |-> !ctrl.memPowerOn)
        else $error("power not forced down");
    a_down_rate: assert property (
        pdm.rxDownsample == (pdmConf_q[1] ? 8'h80 : 8'h40))
        else $error("downsample wrong");
    a_reset_done: assert property (
        fifoResetReq |=> fifoRst_q != 4'h0 ##4 (fifoRst_q == 4'h0 || fifoResetReq))
        else $error("fifo reset window wrong");
    a_busy_flags: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS |=>
        s_axi_rdata[1:0] == {2{$past(fifoRst_q) != 4'h0}})
        else $error("reset busy flags wrong");
    a_idle_flag: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS |=>
        s_axi_rdata[2] == !$past(txActive))
        else $error("idle flag wrong");
    c_write: cover property (doWrite);
    c_timeout: cover property (rxTimeoutPulse);
    c_mclk: cover property (mclkTick);
endmodule
`default_nettype wire

// File: hw/audio_serial_pkg.sv
// Purpose: Shared constants and carriers for the audio serial control block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Link, codec, filter and status offsets are local choices
package audio_serial_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_LINK_CONF = 8'h60;
    localparam logic [7:0] OFS_RX_DMA_STAT = 8'h6c;
    localparam logic [7:0] OFS_DMA_STAT_ONE = 8'h70;
    localparam logic [7:0] OFS_CODEC_CONF = 8'ha0;
    localparam logic [7:0] OFS_FIFO_POWER = 8'ha4;
    localparam logic [7:0] OFS_CLK_DIV = 8'hac;
    localparam logic [7:0] OFS_PDM_CONF = 8'hb4;
    localparam logic [7:0] OFS_PDM_FREQ = 8'hb8;
    localparam logic [7:0] OFS_STATUS = 8'hbc;
    // Link configuration field positions
    localparam int B_TX_DATA_BURST = 0;
    localparam int B_RX_DSCR_BURST = 1;
    localparam int B_TX_DSCR_BURST = 2;
    localparam int B_EOF_MODE = 3;
    localparam int B_AUTO_WRBACK = 4;
    localparam int B_TX_LOOP = 5;
    localparam int B_RX_LOOP = 6;
    localparam int B_BUS_RST = 7;
    localparam int B_QUEUE_RST = 8;
    localparam int B_TX_FSM_RST = 9;
    localparam int B_RX_FSM_RST = 10;
    // Codec configuration field positions
    localparam int B_TIMEOUT_EN = 8;
    localparam int B_TX_STOP = 9;
    localparam int B_RX_CMP_BYP = 10;
    localparam int B_RX_CMP_DIR = 11;
    localparam int B_TX_CMP_BYP = 12;
    localparam int B_TX_CMP_DIR = 13;
    // Power control field positions
    localparam int B_FORCE_PU = 0;
    localparam int B_FORCE_PD = 1;
    // Reset values
    localparam logic [31:0] RST_LINK = 32'h0000_0000;
    localparam logic [31:0] RST_CODEC = 32'h0000_00ff;
    localparam logic [31:0] RST_CLK = 32'h0000_0004;
    localparam logic [31:0] RST_PDM = 32'h0000_0155;
    localparam logic [31:0] RST_FREQ = 32'h0001_e030;
    localparam logic [7:0] DIV_MIN = 8'h02;
    localparam logic [3:0] FIFO_RST_CYCLES = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SINC_BASE = 64;
    localparam int DSR_HIGH = 128;
    localparam int DSR_LOW = 64;

    typedef enum logic [1:0] {
        GAIN_HALF = 2'h0,
        GAIN_ONE = 2'h1,
        GAIN_TWO = 2'h2,
        GAIN_FOUR = 2'h3
    } gain_t;

    // Decoded link and serial control
    typedef struct packed {
        logic txDataBurst;
        logic rxDscrBurst;
        logic txDscrBurst;
        logic autoWriteback;
        logic txLoop;
        logic rxLoop;
        logic busPortReset;
        logic cmdQueueReset;
        logic txFsmReset;
        logic rxFsmReset;
        logic rxCompandBypass;
        logic rxCompress;
        logic txCompandBypass;
        logic txCompress;
        logic memPowerOn;
        logic apllEnable;
    } ctrl_t;

    // Filter chain settings
    typedef struct packed {
        logic txHighpassBypass;
        logic [7:0] rxDownsample;
        logic [9:0] txUpsample;
        logic d2pEnable;
        logic p2dEnable;
        logic rxPdmEnable;
        logic txPdmEnable;
        logic [9:0] freqParam;
        logic [9:0] sampleParam;
    } pdm_t;
endpackage

// File: tb/audio_link_model.sv
// Purpose: Far-side DMA, FIFO and audio clock events
// Assumes: Clock shared with the block
// Notes: Changes follow a rising edge; pulses last one clock
`timescale 1ns/1ps
`default_nettype none
module audio_link_model (
    // Clock
    input wire logic clock,
    // Event pulses
    output logic dmaPopDone,
    output logic busPushDone,
    output logic txBufferSent,
    output logic fifoResetReq,
    // Levels and status words
    output logic txFifoEmpty,
    output logic txFifoHang,
    output logic rxFifoHang,
    output logic txActive,
    output logic mclkSource,
    output logic [31:0] rxDmaState,
    output logic [31:0] dmaStateOne
);
    logic [3:0] evReq = 4'h0;

    // One bit per event pulse
    assign {fifoResetReq, txBufferSent, busPushDone, dmaPopDone} = evReq;

    // Raise event k for exactly one clock
    task automatic pulse(input int k);
        @(posedge clock);
        evReq[k] <= 1'b1;
        @(posedge clock);
        evReq[k] <= 1'b0;
    endtask

    // Levels and status words
    task automatic setLevels(input logic [3:0] lv, input logic [63:0] st);
        @(posedge clock);
        {txFifoEmpty, txFifoHang, rxFifoHang, txActive} <= lv;
        {rxDmaState, dmaStateOne} <= st;
    endtask

    // Audio clock qualifier is present every cycle
    initial
    begin
        {txFifoEmpty, txFifoHang, rxFifoHang, txActive} = 4'h0;
        {rxDmaState, dmaStateOne} = 64'h0;
        mclkSource = 1'b1;
    end
endmodule
`default_nettype wire

// File: tb/test_audio_serial_ctrl.sv
// Purpose: Self-checking bench for the audio serial control block
// Assumes: Bus moves on rising edges, results read on falling edges
// Notes: Bus answers match queued expectations
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        nTests++; \
        if ((got) !== (exp)) \
        begin \
            errorCnt++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module test_audio_serial_ctrl;
    import audio_serial_pkg::*;
    localparam int LIMIT = 4000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic dmaPopDone, busPushDone, txBufferSent, fifoResetReq, txFifoEmpty;
    wire logic txFifoHang, rxFifoHang, txActive, mclkSource;
    wire logic [31:0] rxDmaState, dmaStateOne;
    ctrl_t ctrl;
    pdm_t pdm;
    gain_t [3:0] txGain;
    logic txEofPulse, descWritebackPulse, txTimeoutPulse, rxTimeoutPulse;
    logic mclkTick, serialClockEnable;
    logic [33:0] rx, rdExp[$];
    logic [1:0] wx, wrExp[$];
    logic [31:0] p;
    logic [63:0] stw;
    logic [3:0] ev;
    int errorCnt = 0, nTests = 0, cycles = 0, seed = 45, tickCnt;

    audio_serial_ctrl #(.HANG_W(8)) i_audio_serial_ctrl (
        .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dmaPopDone, .busPushDone,
        .txBufferSent, .txFifoEmpty, .txFifoHang, .rxFifoHang, .fifoResetReq, .txActive,
        .rxDmaState, .dmaStateOne, .mclkSource, .ctrl, .pdm, .txGain, .txEofPulse,
        .descWritebackPulse, .txTimeoutPulse, .rxTimeoutPulse, .mclkTick, .serialClockEnable
    );
    audio_link_model i_audio_link_model (
        .clock, .dmaPopDone, .busPushDone, .txBufferSent, .fifoResetReq, .txFifoEmpty,
        .txFifoHang, .rxFifoHang, .txActive, .mclkSource, .rxDmaState, .dmaStateOne
    );

    // Clock and run limit
    always #25 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            errorCnt++;
            results();
        end
    end

    // Bus answers against the oldest expectation
    always @(negedge clock)
    begin
        if (s_axi_bvalid && s_axi_bready)
        begin
            wx = wrExp.pop_front();
            `CHK(s_axi_bresp, wx)
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            rx = rdExp.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, rx)
        end
    end

    // Write, each channel released when taken, until the answer
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, b;
        wrExp.push_back(r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(negedge clock);
            {ta, tw, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge clock);
            s_axi_awvalid <= s_axi_awvalid && !ta;
            s_axi_wvalid <= s_axi_wvalid && !tw;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask

    // Read, expectation queued first
    task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic t, v;
        rdExp.push_back({r, d});
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(negedge clock);
            {t, v} = {s_axi_arready, s_axi_rvalid};
            @(posedge clock);
            s_axi_arvalid <= s_axi_arvalid && !t;
        end while (!v);
        s_axi_rready <= 1'b0;
    endtask

    // One far-side event, outputs captured during it
    task automatic evCheck(input int k);
        fork
            i_audio_link_model.pulse(k);
        join_none
        @(posedge clock);
        @(negedge clock);
        ev = {rxTimeoutPulse, txTimeoutPulse, descWritebackPulse, txEofPulse};
        @(posedge clock);
    endtask

    task automatic results();
        $display("Comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        axiRead(OFS_LINK_CONF, RST_LINK, RESP_OKAY);
        axiRead(OFS_CODEC_CONF, RST_CODEC, RESP_OKAY);
        axiRead(OFS_CLK_DIV, RST_CLK, RESP_OKAY);
        axiRead(OFS_PDM_CONF, RST_PDM, RESP_OKAY);
        axiRead(OFS_PDM_FREQ, RST_FREQ, RESP_OKAY);
        axiRead(8'h08, 32'h0, RESP_SLVERR);
        axiWrite(8'h04, 32'hffffffff, RESP_SLVERR);
        axiWrite(OFS_RX_DMA_STAT, 32'h1, RESP_SLVERR);
        stw = {$random(seed), $random(seed)};
        i_audio_link_model.setLevels(4'h0, stw);
        axiRead(OFS_RX_DMA_STAT, stw[63:32], RESP_OKAY);
        axiRead(OFS_DMA_STAT_ONE, stw[31:0], RESP_OKAY);
        // Link control bits, random and alternating patterns
        for (int k = 0; k < 4; k++)
        begin
            p = k[1] ? (k[0] ? 32'h2aa : 32'h555) : $random(seed) & 32'h7ff;
            axiWrite(OFS_LINK_CONF, p, RESP_OKAY);
            @(negedge clock);
            `CHK({ctrl.txDataBurst, ctrl.rxDscrBurst}, {p[0], p[1]})
            `CHK(ctrl.txDscrBurst, p[2])
            `CHK({ctrl.autoWriteback, ctrl.txLoop, ctrl.rxLoop}, {p[4], p[5], p[6]})
            `CHK({ctrl.busPortReset, ctrl.cmdQueueReset}, {p[7], p[8]})
            `CHK({ctrl.txFsmReset, ctrl.rxFsmReset}, {p[9], p[10]})
            axiRead(OFS_LINK_CONF, p, RESP_OKAY);
        end
        // End-of-frame source and writeback, both modes
        for (int m = 0; m < 2; m++)
        begin
            axiWrite(OFS_LINK_CONF, m[0] ? 32'h18 : 32'h0, RESP_OKAY);
            evCheck(0);
            `CHK(ev, {3'h0, m[0]})
            evCheck(1);
            `CHK(ev, {3'h0, !m[0]})
            evCheck(2);
            `CHK(ev, {2'h0, m[0], 1'b0})
        end
        // Hang timeout: disabled, transmit side, receive side
        for (int j = 0; j < 3; j++)
        begin
            axiWrite(OFS_CODEC_CONF, (j != 0) ? 32'h103 : 32'h003, RESP_OKAY);
            i_audio_link_model.setLevels((j == 2) ? 4'h2 : 4'h4, stw);
            ev = 4'h0;
            repeat (12)
            begin
                @(negedge clock);
                ev = ev | {rxTimeoutPulse, txTimeoutPulse, 2'h0};
            end
            `CHK(ev[3:2], (j == 0) ? 2'h0 : ((j == 1) ? 2'h1 : 2'h2))
            i_audio_link_model.setLevels(4'h0, stw);
        end
        // Serial clock stop while the transmit FIFO is empty
        for (int s = 0; s < 4; s++)
        begin
            axiWrite(OFS_CODEC_CONF, s[1] ? 32'h200 : 32'h0, RESP_OKAY);
            i_audio_link_model.setLevels({s[0], 3'h0}, stw);
            @(negedge clock);
            `CHK(serialClockEnable, !(s[1] && s[0]))
        end
        // All companding combinations
        for (int i = 0; i < 16; i++)
        begin
            axiWrite(OFS_CODEC_CONF, i << 10, RESP_OKAY);
            @(negedge clock);
            `CHK({ctrl.rxCompandBypass, ctrl.rxCompress}, {i[0], i[1]})
            `CHK({ctrl.txCompandBypass, ctrl.txCompress}, {i[2], i[3]})
        end
        // Forced FIFO memory power, down wins over up
        for (int v = 1; v < 4; v++)
        begin
            axiWrite(OFS_FIFO_POWER, v, RESP_OKAY);
            @(negedge clock);
            `CHK(ctrl.memPowerOn, v == 1)
        end
        // Filter settings, largest oversampling first
        for (int k = 0; k < 3; k++)
        begin
            p = (k == 0) ? 32'h0f003fff : $random(seed) & 32'h0f003fff;
            axiWrite(OFS_PDM_CONF, p, RESP_OKAY);
            @(negedge clock);
            `CHK(pdm.txHighpassBypass, p[0])
            `CHK(pdm.rxDownsample, p[1] ? 8'(DSR_HIGH) : 8'(DSR_LOW))
            `CHK(txGain, p[9:2])
            `CHK(pdm.txUpsample, 10'(SINC_BASE * p[13:10]))
            `CHK({pdm.txPdmEnable, pdm.rxPdmEnable, pdm.p2dEnable, pdm.d2pEnable}, p[27:24])
        end
        p = $random(seed) & 32'hfffff;
        axiWrite(OFS_PDM_FREQ, p, RESP_OKAY);
        @(negedge clock);
        `CHK({pdm.freqParam, pdm.sampleParam}, p[19:0])
        // Divider 4 plus 1/2 with audio PLL enabled: 20 ticks in 90 cycles
        axiWrite(OFS_CLK_DIV, 32'h00208104, RESP_OKAY);
        axiRead(OFS_CLK_DIV, 32'h00208104, RESP_OKAY);
        @(negedge clock);
        `CHK(ctrl.apllEnable, 1'b1)
        tickCnt = 0;
        repeat (90)
        begin
            @(negedge clock);
            tickCnt += int'(mclkTick);
        end
        `CHK(tickCnt >= 19 && tickCnt <= 21, 1'b1)
        // FIFO reset window and transmitter idle flag
        i_audio_link_model.setLevels(4'h1, stw);
        i_audio_link_model.pulse(3);
        axiRead(OFS_STATUS, 32'h3, RESP_OKAY);
        repeat (8) @(posedge clock);
        axiRead(OFS_STATUS, 32'h0, RESP_OKAY);
        i_audio_link_model.setLevels(4'h0, stw);
        axiRead(OFS_STATUS, 32'h4, RESP_OKAY);
        repeat (4) @(posedge clock);
        results();
    end
endmodule
`default_nettype wire
